// *** hw/axil_reg_port.sv ***
// AXI4-Lite slave front end turning bus transfers into byte register strobes
`timescale 1ns/1ps
`default_nettype none
module axil_reg_port #(
    parameter int ADDR_W = 4
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    output logic                   wr_stb,
    output logic [ADDR_W-1:0]      wr_addr,
    output logic [7:0]             wr_data,
    output logic                   wr_lane0,
    input  wire logic              wr_err,
    output logic                   rd_stb,
    output logic [ADDR_W-1:0]      rd_addr,
    input  wire logic [7:0]        rd_value,
    input  wire logic              rd_err
);
    import timer_pkg::*;

    logic              aw_held_r;
    logic              w_held_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [7:0]        wdata_r;
    logic              lane0_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              rvalid_r;
    logic [1:0]        rresp_r;
    logic [31:0]       rdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // Address and data are held separately so either may arrive first
    assign awready  = ~aw_held_r;
    assign wready   = ~w_held_r;
    assign wr_stb   = aw_held_r & w_held_r & ~bvalid_r;
    assign wr_addr  = awaddr_r;
    assign wr_data  = wdata_r;
    assign wr_lane0 = lane0_r;
    assign bvalid   = bvalid_r;
    assign bresp    = bresp_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awaddr_r  <= '0;
            wdata_r   <= BYTE_ZERO;
            lane0_r   <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_held_r <= 1'b1;
                awaddr_r  <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_held_r <= 1'b1;
                wdata_r  <= wdata[7:0];
                lane0_r  <= wstrb[0];
            end
            if (wr_stb)
            begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_err ? RESP_SLVERR : RESP_OKAY;
            end
            else if (bvalid_r && bready)
                bvalid_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reads are answered one edge after the address is taken
    assign arready = ~rvalid_r;
    assign rd_stb  = arvalid & arready;
    assign rd_addr = araddr;
    assign rvalid  = rvalid_r;
    assign rresp   = rresp_r;
    assign rdata   = rdata_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            rresp_r  <= RESP_OKAY;
            rdata_r  <= 32'h0000_0000;
        end
        else if (rd_stb)
        begin
            rvalid_r <= 1'b1;
            rresp_r  <= rd_err ? RESP_SLVERR : RESP_OKAY;
            rdata_r  <= {24'h00_0000, rd_value};
        end
        else if (rvalid_r && rready)
            rvalid_r <= 1'b0;
    end
endmodule : axil_reg_port
`default_nettype wire

// *** hw/count_tick_gen.sv ***
// Counting clock selection, prescaler and external clock alignment
`timescale 1ns/1ps
`default_nettype none
module count_tick_gen (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       run,
    input  wire logic       src_ext,
    input  wire logic       no_sync,
    input  wire logic [1:0] ps_code,
    input  wire logic       ext_level,
    input  wire logic       ps_clear,
    output logic            tick
);
    import timer_pkg::*;

    logic [PS_W-1:0] ps_cnt_r;
    logic [PS_W-1:0] ps_cnt_nxt;
    logic [PS_W-1:0] ps_mask;
    logic            ext_prev_r;
    logic            ext_rise;
    logic            src_event;
    logic            ps_full;
    logic            pre_pulse;
    logic            align1_r;
    logic            align2_r;
    logic            align3_r;
    logic            use_align;

    ////////////////////////////////////////////////////////////////////////////
    // Codes 0..3 give ratios 1, 2, 4, 8
    function automatic logic [PS_W-1:0] ratio_mask(input logic [1:0] code);
        ratio_mask = PS_W'((4'h1 << code) - 4'h1);
    endfunction : ratio_mask

    assign ps_mask    = ratio_mask(ps_code);
    assign ext_rise   = ext_level & ~ext_prev_r;
    assign src_event  = run & (src_ext ? ext_rise : 1'b1);
    assign ps_full    = (ps_cnt_r & ps_mask) == ps_mask;
    assign pre_pulse  = src_event & ps_full;
    assign ps_cnt_nxt = ps_clear ? PS_RESET
                      : !src_event ? ps_cnt_r
                      : ps_full ? PS_RESET
                      : PS_W'(ps_cnt_r + 3'h1);
    // Sync select only matters on the external source
    assign use_align  = src_ext & ~no_sync;
    assign tick       = use_align ? (align2_r & ~align3_r) : pre_pulse;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ps_cnt_r   <= PS_RESET;
            ext_prev_r <= 1'b0;
            align1_r   <= 1'b0;
            align2_r   <= 1'b0;
            align3_r   <= 1'b0;
        end
        else
        begin
            ps_cnt_r   <= ps_cnt_nxt;
            ext_prev_r <= ext_level;
            align1_r   <= pre_pulse;
            align2_r   <= align1_r;
            align3_r   <= align2_r;
        end
    end
endmodule : count_tick_gen
`default_nettype wire

// *** hw/timer_counter.sv ***
// 16-bit timer/counter with byte or buffered 16-bit access over AXI4-Lite
//
// Notes on behaviour
// - Counter advances only while run_enable is set
// - Source: instruction cycles or external rising edges
// - Prescale codes 11..00 divide by 8,4,2,1
// - sync_disable skips external clock alignment; ignored when internal
// - crystal_osc_enable switches oscillator amplifier on/off
// - Status bit shows system clock from crystal
// - wide_access_mode selects buffered 16-bit access
// - Low-byte read copies high byte into buffer
// - Low-byte write loads high byte from buffer
// - Wide mode: high-byte address hits buffer only
// - Low-byte write clears prescaler; high write not
// - Enabled: clock pins inputs, port reads zero
// - Oscillator keeps running in low-power states
// - Counter wraps at maximum, sets sticky overflow_flag
// - Interrupt request needs overflow_irq_enable set
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module timer_counter (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [3:0] s_axi_awaddr,
    input  wire logic       s_axi_awvalid,
    output logic            s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0] s_axi_wstrb,
    input  wire logic       s_axi_wvalid,
    output logic            s_axi_wready,
    output logic [1:0]      s_axi_bresp,
    output logic            s_axi_bvalid,
    input  wire logic       s_axi_bready,
    input  wire logic [3:0] s_axi_araddr,
    input  wire logic       s_axi_arvalid,
    output logic            s_axi_arready,
    output logic [31:0]     s_axi_rdata,
    output logic [1:0]      s_axi_rresp,
    output logic            s_axi_rvalid,
    input  wire logic       s_axi_rready,
    input  wire logic [1:0] pin_in,
    input  wire logic [1:0] port_direction,
    input  wire logic [1:0] port_latch,
    output logic [1:0]      pin_out,
    output logic [1:0]      pin_oe,
    output logic [1:0]      port_read,
    input  wire logic       sysclk_is_crystal,
    output logic            osc_amp_enable,
    output logic            irq_request
);
    import timer_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic        wr_stb;
    logic [3:0]  wr_addr;
    logic [7:0]  wr_data;
    logic        wr_lane0;
    logic        wr_err;
    logic        rd_stb;
    logic [3:0]  rd_addr;
    logic [7:0]  rd_value;
    logic        rd_err;

    logic [7:0]  ctrl_r;
    logic [7:0]  ctrl_nxt;

    logic [15:0] count_r;
    logic [15:0] count_nxt;
    logic [15:0] count_inc;

    logic [7:0]  hi_buf_r;
    logic [7:0]  hi_buf_nxt;

    logic        flag_r;
    logic        flag_nxt;
    logic        irq_en_r;
    logic        irq_en_nxt;

    // Two-flop synchronisers
    logic [1:0]  pin_s1_r;
    logic [1:0]  pin_s2_r;
    logic        stat_s1_r;
    logic        stat_s2_r;

    logic [1:0]  pin_out_r;
    logic [1:0]  pin_oe_r;
    logic [1:0]  port_read_r;
    logic        irq_r;

    logic        run;
    logic        wide;
    logic        tick;
    logic        tick_ok;

    logic        ovf_set;
    logic        flag_clr;

    logic        wr_ctrl;
    logic        wr_lo;
    logic        wr_hi;
    logic        wr_irq;
    logic        rd_lo;
    logic        rd_hi;

    logic [7:0]  ctrl_view;
    logic [7:0]  hi_view;
    logic [7:0]  irq_view;

    ////////////////////////////////////////////////////////////////////////////
    // Bus front end
    axil_reg_port #(
        .ADDR_W (4)
    ) u_port (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .awaddr   (s_axi_awaddr),
        .awvalid  (s_axi_awvalid),
        .awready  (s_axi_awready),
        .wdata    (s_axi_wdata),
        .wstrb    (s_axi_wstrb),
        .wvalid   (s_axi_wvalid),
        .wready   (s_axi_wready),
        .bresp    (s_axi_bresp),
        .bvalid   (s_axi_bvalid),
        .bready   (s_axi_bready),
        .araddr   (s_axi_araddr),
        .arvalid  (s_axi_arvalid),
        .arready  (s_axi_arready),
        .rdata    (s_axi_rdata),
        .rresp    (s_axi_rresp),
        .rvalid   (s_axi_rvalid),
        .rready   (s_axi_rready),
        .wr_stb   (wr_stb),
        .wr_addr  (wr_addr),
        .wr_data  (wr_data),
        .wr_lane0 (wr_lane0),
        .wr_err   (wr_err),
        .rd_stb   (rd_stb),
        .rd_addr  (rd_addr),
        .rd_value (rd_value),
        .rd_err   (rd_err)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Address decode
    function automatic logic is_mapped(input logic [3:0] a);
        is_mapped = (a == ADDR_CTRL) || (a == ADDR_CNT_LO) ||
                    (a == ADDR_CNT_HI) || (a == ADDR_IRQ);
    endfunction : is_mapped

    // A write with byte lane 0 off changes nothing but is still answered
    assign wr_err  = ~is_mapped(wr_addr);
    assign rd_err  = ~is_mapped(rd_addr);

    assign wr_ctrl = wr_stb & wr_lane0 & (wr_addr == ADDR_CTRL);
    assign wr_lo   = wr_stb & wr_lane0 & (wr_addr == ADDR_CNT_LO);
    assign wr_hi   = wr_stb & wr_lane0 & (wr_addr == ADDR_CNT_HI);
    assign wr_irq  = wr_stb & wr_lane0 & (wr_addr == ADDR_IRQ);

    assign rd_lo   = rd_stb & (rd_addr == ADDR_CNT_LO);
    assign rd_hi   = rd_stb & (rd_addr == ADDR_CNT_HI);

    ////////////////////////////////////////////////////////////////////////////
    // Control register
    assign run      = ctrl_r[RUN_BIT];
    assign wide     = ctrl_r[WIDE_BIT];

    assign ctrl_nxt = wr_ctrl ? (wr_data & CTRL_WMASK) : ctrl_r;

    // Status bit is live, never stored
    assign ctrl_view = {ctrl_r[WIDE_BIT], stat_s2_r, ctrl_r[5:0]};

    ////////////////////////////////////////////////////////////////////////////
    // Counting clock
    count_tick_gen u_tick (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .run       (run),
        .src_ext   (ctrl_r[SRC_BIT]),
        .no_sync   (ctrl_r[NOSYNC_BIT]),
        .ps_code   (ctrl_r[PS_LO+1:PS_LO]),
        .ext_level (pin_s2_r[0]),
        .ps_clear  (wr_lo),
        .tick      (tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Counter and high-byte buffer; a software write beats a tick
    assign tick_ok   = tick & run;

    assign count_inc = tick_ok ? 16'(count_r + 16'h0001) : count_r;

    assign count_nxt = wr_lo ? (wide ? {hi_buf_r, wr_data}
                                     : {count_r[15:8], wr_data})
                     : (wr_hi && !wide) ? {wr_data, count_r[7:0]}
                     : count_inc;

    // Buffer takes a high write in wide mode, else a low read snapshot
    assign hi_buf_nxt = (wr_hi && wide) ? wr_data
                      : (rd_lo && wide) ? count_r[15:8]
                      : hi_buf_r;

    assign hi_view = wide ? hi_buf_r : count_r[7+8:8];

    ////////////////////////////////////////////////////////////////////////////
    // Overflow flag: hardware set wins over a software clear
    assign ovf_set    = tick_ok & (count_r == COUNT_MAX) & ~wr_lo
                      & ~(wr_hi & ~wide);

    assign flag_clr   = wr_irq & wr_data[FLAG_BIT];
    assign flag_nxt   = ovf_set | (flag_r & ~flag_clr);

    assign irq_en_nxt = wr_irq ? wr_data[IEN_BIT] : irq_en_r;

    assign irq_view   = {6'h00, irq_en_r, flag_r};

    ////////////////////////////////////////////////////////////////////////////
    // Read data selection
    // Unmapped addresses read as zero
    assign rd_value = (rd_addr == ADDR_CTRL)   ? ctrl_view
                    : (rd_addr == ADDR_CNT_LO) ? count_r[7:0]
                    : (rd_addr == ADDR_CNT_HI) ? hi_view
                    : (rd_addr == ADDR_IRQ)    ? irq_view
                    : BYTE_ZERO;

    ////////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_r   <= CTRL_RESET;
            count_r  <= COUNT_RESET;
            hi_buf_r <= BYTE_ZERO;
            flag_r   <= 1'b0;
            irq_en_r <= 1'b0;
        end
        else
        begin
            ctrl_r   <= ctrl_nxt;
            count_r  <= count_nxt;
            hi_buf_r <= hi_buf_nxt;
            flag_r   <= flag_nxt;
            irq_en_r <= irq_en_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin and status synchronisers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_s1_r  <= 2'h0;
            pin_s2_r  <= 2'h0;
            stat_s1_r <= 1'b0;
            stat_s2_r <= 1'b0;
        end
        else
        begin
            pin_s1_r  <= pin_in;
            pin_s2_r  <= pin_s1_r;
            stat_s1_r <= sysclk_is_crystal;
            stat_s2_r <= stat_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin ownership and outputs
    // While running the port direction bits are overridden
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_out_r   <= 2'h0;
            pin_oe_r    <= 2'h0;
            port_read_r <= 2'h0;
            irq_r       <= 1'b0;
        end
        else
        begin
            pin_out_r   <= port_latch;
            pin_oe_r    <= run ? 2'h0 : ~port_direction;
            port_read_r <= run ? 2'h0 : pin_s2_r;
            irq_r       <= flag_nxt & irq_en_nxt;
        end
    end

    assign pin_out     = pin_out_r;
    assign pin_oe      = pin_oe_r;
    assign port_read   = port_read_r;

    assign irq_request = irq_r;

    // No power-mode input gates the amplifier, so it never stops in sleep
    assign osc_amp_enable = ctrl_r[OSC_BIT];
endmodule : timer_counter
`default_nettype wire

// *** inc/timer_pkg.sv ***
// Shared constants for the 16-bit timer/counter and its register port
package timer_pkg;
    // Register byte addresses
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_CNT_LO = 4'h4;
    localparam logic [3:0] ADDR_CNT_HI = 4'h8;
    localparam logic [3:0] ADDR_IRQ    = 4'hC;
    // Control register fields
    localparam int RUN_BIT  = 0;
    localparam int SRC_BIT  = 1;
    localparam int NOSYNC_BIT = 2;
    localparam int OSC_BIT  = 3;
    localparam int PS_LO    = 4;
    localparam int STAT_BIT = 6;
    localparam int WIDE_BIT = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_WMASK = 8'hBF;
    // Interrupt register fields
    localparam int FLAG_BIT = 0;
    localparam int IEN_BIT  = 1;
    // Counter limits
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
    localparam logic [7:0]  BYTE_ZERO   = 8'h00;
    // Prescaler
    localparam int PS_W = 3;
    localparam logic [PS_W-1:0] PS_RESET = 3'h0;
    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : timer_pkg

// *** verification/crystal_model.sv ***
// Behavioural crystal on the oscillator pins
`timescale 1ns/1ps
`default_nettype none
module crystal_model #(
    parameter int HALF    = 2,
    parameter int STARTUP = 32
) (
    input  wire logic       aclk,
    input  wire logic       amp_enable,
    output logic [1:0]      pins
);
    int age = 0;
    int div = 0;

    ////////////////////////////////////////////////////////////
    // No edges until start-up time has passed
    always @(posedge aclk)
    begin
        if (amp_enable !== 1'b1)
        begin
            age  <= 0;
            div  <= 0;
            pins <= 2'h2;
        end
        else if (age < STARTUP)
            age <= age + 1;
        else
        begin
            div <= (div == HALF - 1) ? 0 : div + 1;
            if (div == HALF - 1)
                pins <= ~pins;
        end
    end
endmodule : crystal_model
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the timer/counter
`timescale 1ns/1ps
`default_nettype none
module tb;
    import timer_pkg::*;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready = 1'b0;
    logic [3:0]  s_axi_araddr = 4'h0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready = 1'b0;
    logic [1:0]  pin_in;
    logic [1:0]  port_direction = 2'h1;
    logic [1:0]  port_latch = 2'h2;
    logic [1:0]  pin_out;
    logic [1:0]  pin_oe;
    logic [1:0]  port_read;
    logic        sysclk_is_crystal = 1'b0;
    logic        osc_amp_enable;
    logic        irq_request;
    logic [3:0]  strb = 4'hF;
    logic [31:0] v;
    logic [1:0]  resp;
    int          fail_count = 0;
    int          checks = 0;
    int          cycles = 0;

    timer_counter uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .port_direction,
        .port_latch, .pin_out, .pin_oe, .port_read, .sysclk_is_crystal, .osc_amp_enable,
        .irq_request);
    crystal_model xtal (.aclk, .amp_enable(osc_amp_enable), .pins(pin_in));

    always #12.5 aclk = ~aclk;

    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fail_count++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [3:0] ad, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr  <= ad;
        s_axi_wdata   <= {24'h000000, d};
        s_axi_wstrb   <= strb;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] ad);
        @(posedge aclk);
        s_axi_araddr  <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic rchk(input string n, input logic [3:0] ad, input logic [7:0] e);
        rd(ad);
        chk(n, 32'(e), v);
    endtask : rchk

    // Low-byte reads 128 cycles apart, w high writes between
    task automatic rate(input logic [7:0] c, input int w, input logic [7:0] e);
        logic [7:0] a0;
        wr(ADDR_CTRL, c);
        repeat (24) @(posedge aclk);
        rd(ADDR_CNT_LO);
        a0 = v[7:0];
        repeat (w) wr(ADDR_CNT_HI, 8'h00);
        repeat (125 - 4 * w) @(posedge aclk);
        rd(ADDR_CNT_LO);
        chk("count step", 32'(e), {24'h000000, v[7:0] - a0});
    endtask : rate

    ////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rchk("ctrl", ADDR_CTRL, 8'h00);
        rchk("irq", ADDR_IRQ, 8'h00);
        chk("pin_oe", 32'h2, 32'(pin_oe));
        chk("port_read", 32'h2, 32'(port_read));
        chk("pin_out", 32'h2, 32'(pin_out));
        rd(4'h2);
        chk("rresp", 32'(RESP_SLVERR), 32'(resp));
        wr(4'h2, 8'h55);
        chk("bresp", 32'(RESP_SLVERR), 32'(resp));
        strb = 4'hE;
        wr(ADDR_CTRL, 8'hFF);
        strb = 4'hF;
        rchk("ctrl", ADDR_CTRL, 8'h00);
        wr(ADDR_CTRL, 8'hFE);
        rchk("ctrl", ADDR_CTRL, 8'hBE);
        chk("osc", 32'h1, 32'(osc_amp_enable));
        sysclk_is_crystal <= 1'b1;
        @(posedge aclk);
        rchk("ctrl", ADDR_CTRL, 8'hFE);
        wr(ADDR_CTRL, 8'h00);
        rchk("ctrl", ADDR_CTRL, 8'h40);
        chk("osc", 32'h0, 32'(osc_amp_enable));
        sysclk_is_crystal <= 1'b0;
        // Buffered access, counter stopped
        wr(ADDR_CTRL, 8'h80);
        wr(ADDR_CNT_HI, 8'hAB);
        rchk("hi buf", ADDR_CNT_HI, 8'hAB);
        wr(ADDR_CNT_LO, 8'hCD);
        wr(ADDR_CTRL, 8'h00);
        rchk("hi", ADDR_CNT_HI, 8'hAB);
        rchk("lo", ADDR_CNT_LO, 8'hCD);
        wr(ADDR_CNT_HI, 8'h12);
        wr(ADDR_CNT_LO, 8'h34);
        wr(ADDR_CTRL, 8'h80);
        wr(ADDR_CNT_HI, 8'h77);
        rchk("hi buf", ADDR_CNT_HI, 8'h77);
        rchk("lo", ADDR_CNT_LO, 8'h34);
        rchk("hi snap", ADDR_CNT_HI, 8'h12);
        wr(ADDR_CTRL, 8'h08);
        repeat (40) @(posedge aclk);
        rate(8'h08, 0, 8'h00);
        for (int i = 0; i < 16; i++)
            rate({2'h0, 2'(i), 1'b1, 1'(i >> 2), 1'(i >> 3), 1'b1}, 0,
                8'(128 >> (i % 4 + 2 * (i / 8))));
        chk("pin_oe run", 32'h0, 32'(pin_oe));
        chk("port_read run", 32'h0, 32'(port_read));
        chk("osc", 32'h1, 32'(osc_amp_enable));
        rate(8'hB9, 2, 8'h10);
        // Overflow, mask, clear
        wr(ADDR_CTRL, 8'h08);
        wr(ADDR_CNT_HI, 8'hFF);
        wr(ADDR_CNT_LO, 8'hFE);
        wr(ADDR_IRQ, 8'h02);
        wr(ADDR_CTRL, 8'h09);
        repeat (8) @(posedge aclk);
        wr(ADDR_CTRL, 8'h08);
        rchk("irq", ADDR_IRQ, 8'h03);
        rchk("hi wrap", ADDR_CNT_HI, 8'h00);
        chk("irq_request", 32'h1, 32'(irq_request));
        wr(ADDR_IRQ, 8'h00);
        chk("irq_request", 32'h0, 32'(irq_request));
        rchk("irq", ADDR_IRQ, 8'h01);
        wr(ADDR_IRQ, 8'h01);
        rchk("irq", ADDR_IRQ, 8'h00);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rchk("ctrl", ADDR_CTRL, 8'h00);
        chk("osc", 32'h0, 32'(osc_amp_enable));
        final_report();
    end
endmodule : tb
`default_nettype wire

// *** verification/timer_counter_checker.sv ***
// Assertions on the timer's ports
`timescale 1ns/1ps
`default_nettype none
module timer_counter_checker (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [1:0]  port_direction,
    input wire logic [1:0]  pin_oe,
    input wire logic [1:0]  port_read,
    input wire logic        osc_amp_enable,
    input wire logic        irq_request
);
    import timer_pkg::*;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> !s_axi_awready && !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response late");
    a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid ##1 s_axi_awready)
        else $error("bvalid held");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data late");
    a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("rvalid held");
    a_ready_mirror: assert property (s_axi_arready != s_axi_rvalid)
        else $error("arready equals rvalid");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("rdata upper bits set");
    a_pins_freed: assert property
        (port_read != 2'h0 |-> pin_oe == ~$past(port_direction))
        else $error("pin enables ignore direction");
    a_reset_values: assert property ($rose(aresetn) |-> !irq_request
        && pin_oe == 2'h0 && port_read == 2'h0 && !osc_amp_enable && !s_axi_bvalid)
        else $error("bad reset values");
    a_osc_on_write: assert property
        ($changed(osc_amp_enable) |-> $rose(s_axi_bvalid))
        else $error("osc enable moved without write");
    a_flag_sticky: assert property ($fell(irq_request) |-> $rose(s_axi_bvalid))
        else $error("irq dropped without write");

    c_irq_raised: cover property ($rose(irq_request));
    c_slave_error: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
    c_pins_read: cover property (port_read != 2'h0);
endmodule : timer_counter_checker

bind timer_counter timer_counter_checker chk_i (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .port_direction, .pin_oe, .port_read, .osc_amp_enable, .irq_request);
`default_nettype wire
